/* verilog/esp_pkg.sv */
// package: constants, types and register map of the enhanced serial port
`default_nettype none
package esp_pkg;

  // ******************************
  // register offsets
  // ******************************
  localparam logic [7:0] ESP_OFF_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ESP_OFF_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] ESP_OFF_SERIAL_DATA_BUFFER = 8'h99;
  localparam logic [7:0] ESP_OFF_SERIAL_OWN_ADDRESS = 8'ha9;
  localparam logic [7:0] ESP_OFF_SERIAL_ADDRESS_MASK = 8'hb9;
  localparam logic [7:0] ESP_OFF_SERIAL_STATUS = 8'hba;
  localparam logic [7:0] ESP_OFF_BAUD_GEN_CONTROL = 8'hbd;
  localparam logic [7:0] ESP_OFF_BAUD_RATE_LOW = 8'hbe;
  localparam logic [7:0] ESP_OFF_BAUD_RATE_HIGH = 8'hbf;

  // ******************************
  // field positions
  // ******************************
  localparam int ESP_PC_RATE_DOUBLE = 7;
  localparam int ESP_PC_FE_VIEW = 6;
  localparam int ESP_SC_MODE0_FE = 7;
  localparam int ESP_SC_MODE1 = 6;
  localparam int ESP_SC_MP_EN = 5;
  localparam int ESP_SC_RX_EN = 4;
  localparam int ESP_SC_TX_NINTH = 3;
  localparam int ESP_SC_RX_NINTH = 2;
  localparam int ESP_SC_TX_FLAG = 1;
  localparam int ESP_SC_RX_FLAG = 0;
  localparam int ESP_SS_FE = 3;
  localparam int ESP_BG_SELECT = 1;
  localparam int ESP_BG_ENABLE = 0;
  localparam logic [7:0] ESP_RST_BYTE = 8'h00;

  // ******************************
  // rate divisors and frame lengths
  // ******************************
  localparam logic [17:0] ESP_M0_DIV = 18'h0_0010;
  localparam logic [17:0] ESP_M2_DIV_SLOW = 18'h0_0020;
  localparam logic [17:0] ESP_M2_DIV_FAST = 18'h0_0010;
  localparam logic [17:0] ESP_BRG_OFFSET = 18'h0_0010;
  localparam logic [17:0] ESP_T1_SPAN = 18'h0_0100;
  localparam int ESP_T1_SHIFT_SLOW = 6;
  localparam int ESP_T1_SHIFT_FAST = 5;
  localparam logic [3:0] ESP_BITS_M0 = 4'h8;
  localparam logic [3:0] ESP_BITS_8N = 4'ha;
  localparam logic [3:0] ESP_BITS_9N = 4'hb;
  localparam logic [3:0] ESP_RX_SAMPLES_8N = 4'h9;
  localparam logic [3:0] ESP_RX_SAMPLES_9N = 4'ha;

  // ******************************
  // types
  // ******************************
  typedef enum logic [1:0] {
    ESP_MODE_SHIFT = 2'b00,
    ESP_MODE_UART8 = 2'b01,
    ESP_MODE_UART9_FIXED = 2'b10,
    ESP_MODE_UART9_VAR = 2'b11
  } esp_mode_t;

  typedef enum logic [1:0] {
    ESP_RX_IDLE = 2'b00,
    ESP_RX_START = 2'b01,
    ESP_RX_DATA = 2'b10,
    ESP_RX_SHIFT = 2'b11
  } esp_rx_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } esp_bus_req_t;

  typedef struct packed {
    logic [7:0] power_control;
    logic mode_select_0;
    logic mode_select_1;
    logic multiprocessor_enable;
    logic rx_enable;
    logic transmit_ninth_bit;
    logic received_ninth_bit;
    logic transmit_interrupt_flag;
    logic receive_interrupt_flag;
    logic framing_error_flag;
    logic [7:0] serial_own_address;
    logic [7:0] serial_address_mask;
    logic [7:0] status_other;
    logic baud_gen_select;
    logic baud_gen_enable;
    logic [7:0] baud_rate_low;
    logic [7:0] baud_rate_high;
    logic tx_busy;
    logic [10:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [17:0] tx_tmr;
    esp_rx_state_t rx_st;
    logic [9:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [17:0] rx_tmr;
    logic [7:0] rx_buf;
    logic rx_s1;
    logic rx_s2;
    logic rx_s3;
    logic txd;
    logic rxd_out;
    logic rxd_oe_n;
    logic [7:0] rdata;
  } esp_state_t;

  localparam esp_state_t ESP_STATE_RST = '{
    rx_st: ESP_RX_IDLE, txd: 1'b1, rxd_oe_n: 1'b1,
    rx_s1: 1'b1, rx_s2: 1'b1, rx_s3: 1'b1, default: '0};

endpackage
`default_nettype wire

/* verilog/esp_serial_port.sv */
// module: enhanced serial port with shift mode, uart modes and baud gen
//
// How it works
// (RULE1) shift mode: data on rxd, clock on txd
// (RULE2) shift mode rate is clock over 16
// (RULE3) 8-bit mode: start, 8 data, stop
// (RULE4) 9-bit modes: start, 9 data, stop
// (RULE5) fixed 9-bit mode: clock over 32 or 16
// (RULE6) variable 9-bit mode uses selected rate source
// (RULE7) data buffer write starts a transmission
// (RULE8) shift receive starts on flag clear, enabled
// (RULE9) async receive starts on start bit, enabled
// (RULE10) timer rate: (256 minus reload) times 64/32
// (RULE11) generator rate: clock over value plus 16
// (RULE12) select bit picks generator over timer
// (RULE13) enable bit runs generator, both reset zero
// (RULE14) software loads rate only while disabled
// (RULE15) low stop bit sets framing error
// (RULE16) view bit maps framing error onto control
// (RULE17) software sets mode with view bit clear
// (RULE18) two select bits choose mode, shift default
// (RULE19) multiprocessor: in 9-bit modes ninth bit zero gives no flag
// (RULE20) shift mode flags set after eighth bit
// (RULE21) async transmit line idles high
// (RULE22) disabled generator holds and gives no ticks
//
// The address-and-strobe port was decided locally.
`default_nettype none
module esp_serial_port
  import esp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire esp_bus_req_t bus,
  output logic [7:0] rdata,
  input wire logic [7:0] timer1_reload_byte,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe_n,
  output logic txd
);

  // ******************************
  // state and helpers
  // ******************************
  esp_state_t st;
  esp_state_t next_st;
  esp_mode_t mode;
  logic [17:0] per;
  logic [17:0] half;
  logic run;
  logic tx_write;
  logic [9:0] rx_v;
  logic rx_done;
  logic set_ti;
  logic set_ri;
  logic set_fe;

  function automatic logic [17:0] bit_period(
    input esp_mode_t m,
    input logic dbl,
    input logic sel,
    input logic [7:0] th1,
    input logic [15:0] brg
  );
    logic [17:0] span;
    span = ESP_T1_SPAN - {10'h000, th1};
    case (m)
      ESP_MODE_SHIFT: bit_period = ESP_M0_DIV; // see (RULE2)
      ESP_MODE_UART9_FIXED: begin // see (RULE5)
        bit_period = dbl ? ESP_M2_DIV_FAST : ESP_M2_DIV_SLOW;
      end
      default: begin // see (RULE6)
        if (sel) begin
          bit_period = {2'b00, brg} + ESP_BRG_OFFSET; // see (RULE11)
        end else if (dbl) begin
          bit_period = span << ESP_T1_SHIFT_FAST; // see (RULE10)
        end else begin
          bit_period = span << ESP_T1_SHIFT_SLOW; // see (RULE10)
        end
      end
    endcase
  endfunction

  assign mode = esp_mode_t'({st.mode_select_0, st.mode_select_1}); // see (RULE18)
  assign per = bit_period(mode, st.power_control[ESP_PC_RATE_DOUBLE],
    st.baud_gen_select, timer1_reload_byte,
    {st.baud_rate_high, st.baud_rate_low});
  assign half = {1'b0, per[17:1]};
  // generator selected but disabled in 8-bit and variable 9-bit modes: timers freeze
  assign run = !(mode[0] && st.baud_gen_select && !st.baud_gen_enable); // see (RULE22) (RULE12)
  assign tx_write = bus.wr && (bus.addr == ESP_OFF_SERIAL_DATA_BUFFER);
  assign rx_v = {st.rx_s2, st.rx_sh[9:1]};
  assign rx_done = (st.rx_st == ESP_RX_DATA) && run && (st.rx_tmr == '0)
    && (st.rx_cnt == 4'h1);

  // ******************************
  // next state
  // ******************************
  always_comb begin
    next_st = st;
    set_ti = 1'b0;
    set_ri = 1'b0;
    set_fe = 1'b0;
    next_st.rdata = '0;
    next_st.rx_s1 = rxd_in;
    next_st.rx_s2 = st.rx_s1;
    next_st.rx_s3 = st.rx_s2;
    if (bus.rd) begin
      case (bus.addr)
        ESP_OFF_POWER_CONTROL: next_st.rdata = st.power_control;
        ESP_OFF_SERIAL_CONTROL: begin
          next_st.rdata = {
            st.power_control[ESP_PC_FE_VIEW] ? st.framing_error_flag
              : st.mode_select_0, // see (RULE16)
            st.mode_select_1, st.multiprocessor_enable, st.rx_enable,
            st.transmit_ninth_bit, st.received_ninth_bit,
            st.transmit_interrupt_flag, st.receive_interrupt_flag};
        end
        ESP_OFF_SERIAL_DATA_BUFFER: next_st.rdata = st.rx_buf;
        ESP_OFF_SERIAL_OWN_ADDRESS: next_st.rdata = st.serial_own_address;
        ESP_OFF_SERIAL_ADDRESS_MASK: next_st.rdata = st.serial_address_mask;
        ESP_OFF_SERIAL_STATUS: begin
          next_st.rdata = {st.status_other[7:4], st.framing_error_flag,
            st.status_other[2:0]}; // see (RULE15)
        end
        ESP_OFF_BAUD_GEN_CONTROL: begin
          next_st.rdata = {6'b00_0000, st.baud_gen_select,
            st.baud_gen_enable}; // see (RULE13)
        end
        ESP_OFF_BAUD_RATE_LOW: next_st.rdata = st.baud_rate_low;
        ESP_OFF_BAUD_RATE_HIGH: next_st.rdata = st.baud_rate_high;
        default: next_st.rdata = '0;
      endcase
    end

    // transmitter
    if (st.tx_busy && run) begin
      if (st.tx_tmr != '0) begin
        next_st.tx_tmr = st.tx_tmr - 18'h0_0001;
      end else if (st.tx_cnt == 4'h1) begin
        next_st.tx_busy = 1'b0;
        if (mode == ESP_MODE_SHIFT) begin
          set_ti = 1'b1; // see (RULE20)
        end
      end else begin
        next_st.tx_sh = {1'b1, st.tx_sh[10:1]}; // see (RULE3) (RULE4)
        next_st.tx_cnt = st.tx_cnt - 4'h1;
        next_st.tx_tmr = per - 18'h0_0001;
        if (st.tx_cnt == 4'h2 && mode != ESP_MODE_SHIFT) begin
          set_ti = 1'b1;
        end
      end
    end

    // receiver
    case (st.rx_st)
      ESP_RX_IDLE: begin
        if (mode == ESP_MODE_SHIFT) begin
          if (st.rx_enable && !st.receive_interrupt_flag && !st.tx_busy
              && !tx_write) begin // see (RULE8)
            next_st.rx_st = ESP_RX_SHIFT;
            next_st.rx_tmr = per - 18'h0_0001;
            next_st.rx_cnt = ESP_BITS_M0;
          end
        end else if (st.rx_enable && run && st.rx_s3 && !st.rx_s2) begin // see (RULE9) (RULE22)
          next_st.rx_st = ESP_RX_START;
          next_st.rx_tmr = half - 18'h0_0001;
        end
      end
      ESP_RX_START: begin
        if (run) begin
          if (st.rx_tmr != '0) begin
            next_st.rx_tmr = st.rx_tmr - 18'h0_0001;
          end else if (!st.rx_s2) begin
            next_st.rx_st = ESP_RX_DATA;
            next_st.rx_tmr = per - 18'h0_0001;
            next_st.rx_cnt = (mode == ESP_MODE_UART8) ? ESP_RX_SAMPLES_8N
              : ESP_RX_SAMPLES_9N;
          end else begin
            next_st.rx_st = ESP_RX_IDLE;
          end
        end
      end
      ESP_RX_DATA: begin
        if (run) begin
          if (st.rx_tmr != '0) begin
            next_st.rx_tmr = st.rx_tmr - 18'h0_0001;
          end else begin
            next_st.rx_sh = rx_v;
            next_st.rx_tmr = per - 18'h0_0001;
            next_st.rx_cnt = st.rx_cnt - 4'h1;
          end
        end
        if (rx_done) begin
          next_st.rx_st = ESP_RX_IDLE;
          set_fe = !rx_v[9]; // see (RULE15)
          if (mode == ESP_MODE_UART8) begin // see (RULE3)
            next_st.rx_buf = rx_v[8:1];
            set_ri = 1'b1;
          end else if (!(st.multiprocessor_enable && !rx_v[8])) begin // see (RULE19)
            next_st.rx_buf = rx_v[7:0]; // see (RULE4)
            set_ri = 1'b1;
          end
        end
      end
      ESP_RX_SHIFT: begin
        if (st.rx_tmr == half) begin
          next_st.rx_sh = rx_v; // see (RULE1)
        end
        if (st.rx_tmr != '0) begin
          next_st.rx_tmr = st.rx_tmr - 18'h0_0001;
        end else if (st.rx_cnt == 4'h1) begin
          next_st.rx_st = ESP_RX_IDLE;
          next_st.rx_buf = st.rx_sh[9:2];
          set_ri = 1'b1; // see (RULE20)
        end else begin
          next_st.rx_cnt = st.rx_cnt - 4'h1;
          next_st.rx_tmr = per - 18'h0_0001;
        end
      end
      default: next_st.rx_st = ESP_RX_IDLE;
    endcase

    // register writes
    if (bus.wr) begin
      case (bus.addr)
        ESP_OFF_POWER_CONTROL: next_st.power_control = bus.wdata;
        ESP_OFF_SERIAL_CONTROL: begin
          if (st.power_control[ESP_PC_FE_VIEW]) begin // see (RULE16)
            next_st.framing_error_flag = bus.wdata[ESP_SC_MODE0_FE];
          end else begin
            next_st.mode_select_0 = bus.wdata[ESP_SC_MODE0_FE];
          end
          next_st.mode_select_1 = bus.wdata[ESP_SC_MODE1];
          next_st.multiprocessor_enable = bus.wdata[ESP_SC_MP_EN];
          next_st.rx_enable = bus.wdata[ESP_SC_RX_EN];
          next_st.transmit_ninth_bit = bus.wdata[ESP_SC_TX_NINTH];
          next_st.received_ninth_bit = bus.wdata[ESP_SC_RX_NINTH];
          next_st.transmit_interrupt_flag = bus.wdata[ESP_SC_TX_FLAG];
          next_st.receive_interrupt_flag = bus.wdata[ESP_SC_RX_FLAG];
        end
        ESP_OFF_SERIAL_DATA_BUFFER: begin // see (RULE7)
          next_st.tx_busy = 1'b1;
          next_st.tx_tmr = per - 18'h0_0001;
          if (mode == ESP_MODE_SHIFT) begin
            next_st.tx_sh = {3'b111, bus.wdata};
            next_st.tx_cnt = ESP_BITS_M0;
          end else if (mode == ESP_MODE_UART8) begin
            next_st.tx_sh = {2'b11, bus.wdata, 1'b0}; // see (RULE3)
            next_st.tx_cnt = ESP_BITS_8N;
          end else begin
            next_st.tx_sh = {1'b1, st.transmit_ninth_bit, bus.wdata,
              1'b0}; // see (RULE4)
            next_st.tx_cnt = ESP_BITS_9N;
          end
        end
        ESP_OFF_SERIAL_OWN_ADDRESS: next_st.serial_own_address = bus.wdata;
        ESP_OFF_SERIAL_ADDRESS_MASK: next_st.serial_address_mask = bus.wdata;
        ESP_OFF_SERIAL_STATUS: begin
          next_st.status_other = bus.wdata;
          next_st.framing_error_flag = bus.wdata[ESP_SS_FE];
        end
        ESP_OFF_BAUD_GEN_CONTROL: begin // see (RULE13)
          next_st.baud_gen_select = bus.wdata[ESP_BG_SELECT];
          next_st.baud_gen_enable = bus.wdata[ESP_BG_ENABLE];
        end
        ESP_OFF_BAUD_RATE_LOW: next_st.baud_rate_low = bus.wdata;
        ESP_OFF_BAUD_RATE_HIGH: next_st.baud_rate_high = bus.wdata;
        default: next_st.rdata = next_st.rdata;
      endcase
    end

    // hardware sets win over software clears
    if (set_ti) begin
      next_st.transmit_interrupt_flag = 1'b1;
    end
    if (set_ri) begin
      next_st.receive_interrupt_flag = 1'b1;
      if (st.rx_st == ESP_RX_DATA) begin
        next_st.received_ninth_bit = (mode == ESP_MODE_UART8) ? rx_v[9]
          : rx_v[8]; // see (RULE3) (RULE4)
      end
    end
    if (set_fe) begin
      next_st.framing_error_flag = 1'b1;
    end

    // pins
    next_st.rxd_oe_n = !(next_st.tx_busy && mode == ESP_MODE_SHIFT); // see (RULE1)
    next_st.rxd_out = next_st.tx_sh[0];
    if (mode == ESP_MODE_SHIFT) begin
      if (next_st.tx_busy) begin
        next_st.txd = next_st.tx_tmr < half; // see (RULE1)
      end else if (next_st.rx_st == ESP_RX_SHIFT) begin
        next_st.txd = next_st.rx_tmr < half;
      end else begin
        next_st.txd = 1'b1;
      end
    end else begin
      next_st.txd = next_st.tx_busy ? next_st.tx_sh[0] : 1'b1; // see (RULE21)
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= ESP_STATE_RST; // see (RULE13) (RULE18)
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign rxd_out = st.rxd_out;
  assign rxd_oe_n = st.rxd_oe_n;
  assign txd = st.txd;

  // ******************************
  // assertions
  // ******************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  idle_line_high_a: assert property ( // see (RULE21)
    (mode != ESP_MODE_SHIFT && !st.tx_busy && st.rx_st != ESP_RX_SHIFT
      && $past(mode) != ESP_MODE_SHIFT) |-> st.txd)
    else $error("async line not idle high");
  start_bit_low_a: assert property ( // see (RULE3)
    (tx_write && mode != ESP_MODE_SHIFT) |=> !st.txd ##1 !st.txd)
    else $error("start bit not low");
  shift_period_a: assert property ( // see (RULE2)
    (tx_write && mode == ESP_MODE_SHIFT) |=> st.tx_busy
      && st.tx_tmr == 18'h0_000f && st.tx_cnt == 4'h8)
    else $error("shift bit period wrong");
  gen_hold_a: assert property ( // see (RULE22)
    (!run && $past(!run) && !$past(bus.wr))
      |-> st.tx_tmr == $past(st.tx_tmr) && st.rx_tmr == $past(st.rx_tmr))
    else $error("disabled generator still counts");
  shift_ti_end_a: assert property ( // see (RULE20)
    (st.tx_busy && run && mode == ESP_MODE_SHIFT && st.tx_cnt == 4'h1
      && st.tx_tmr == 18'h0_0000) |=> st.transmit_interrupt_flag
      && !st.tx_busy)
    else $error("shift transmit flag missed");
  fe_set_a: assert property ( // see (RULE15)
    (rx_done && !st.rx_s2) |=> st.framing_error_flag)
    else $error("framing error not flagged");
  fe_view_read_a: assert property ( // see (RULE16)
    (bus.rd && bus.addr == ESP_OFF_SERIAL_CONTROL
      && st.power_control[ESP_PC_FE_VIEW])
      |=> st.rdata[7] == $past(st.framing_error_flag))
    else $error("control bit 7 not framing error");
  drive_shift_a: assert property ( // see (RULE1)
    !st.rxd_oe_n |-> st.tx_busy && mode == ESP_MODE_SHIFT)
    else $error("rxd driven outside shift send");
  mp_suppress_a: assert property ( // see (RULE19)
    (rx_done && mode[1] && st.multiprocessor_enable && !rx_v[8]
      && !st.receive_interrupt_flag && !bus.wr)
      |=> !st.receive_interrupt_flag)
    else $error("flag set with ninth bit zero");
  rx_start_a: assert property ( // see (RULE9)
    (st.rx_st == ESP_RX_IDLE && !st.rx_enable) |=> st.rx_st == ESP_RX_IDLE)
    else $error("receive started while disabled");

  async_tx_c: cover property (tx_write && mode == ESP_MODE_UART8);
  async_rx_c: cover property (rx_done && st.rx_s2);
  shift_rx_c: cover property (st.rx_st == ESP_RX_SHIFT && st.rx_cnt == 4'h1);
  fe_seen_c: cover property (rx_done && !st.rx_s2);

endmodule
`default_nettype wire

/* testbench/esp_remote_model.sv */
// partner model: remote serial device on the transmit and receive pins
`default_nettype none
module esp_remote_model
  import esp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic txd,
  input wire logic rxd_out,
  input wire logic rxd_oe_n,
  output logic rxd_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ***
  // pin level and shift data
  // ***
  logic line = 1'h1;
  logic [7:0] sh_byte = 8'h00;
  int sh_left = 0;
  // pulled up when neither side drives
  assign rxd_in = rxd_oe_n ? line : rxd_out;
  // next bit at each falling shift clock, lsb first
  always @(negedge txd) begin
    if (sh_left > 0) begin
      line = sh_byte[3'(8 - sh_left)];
      sh_left = sh_left - 1;
    end
  end
  task automatic arm_shift(input logic [7:0] d, input int n);
    sh_byte = d;
    sh_left = n;
    line = 1'h1;
  endtask
  // async frame, bit 0 first, each bit held p cycles
  task automatic send_frame(input logic [10:0] bits, input int n,
      input int p);
    for (int i = 0; i < n; i++) begin
      line <= bits[i];
      repeat (p) @(posedge ref_clk);
    end
    line <= 1'h1;
  endtask
endmodule
`default_nettype wire

/* testbench/esp_serial_port_tb.sv */
// testbench: self-checking bench of the enhanced serial port
`default_nettype none
module esp_serial_port_tb
  import esp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ***
  // setup
  // ***
  localparam logic [7:0] REGS [10] = '{ESP_OFF_POWER_CONTROL,
    ESP_OFF_SERIAL_CONTROL, ESP_OFF_SERIAL_DATA_BUFFER,
    ESP_OFF_SERIAL_OWN_ADDRESS, ESP_OFF_SERIAL_ADDRESS_MASK,
    ESP_OFF_SERIAL_STATUS, ESP_OFF_BAUD_GEN_CONTROL,
    ESP_OFF_BAUD_RATE_LOW, ESP_OFF_BAUD_RATE_HIGH, 8'h90};
  localparam logic [1:0] MODES [7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2,
    2'h3, 2'h3};
  localparam logic SELS [7] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  esp_bus_req_t bus = '0;
  logic [7:0] reload_byte = 8'hff;
  logic [7:0] rdata;
  logic rxd_in;
  logic rxd_out;
  logic rxd_oe_n;
  logic txd;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;

  esp_serial_port dut_u (
    .ref_clk(ref_clk),
    .rst(rst),
    .bus(bus),
    .rdata(rdata),
    .timer1_reload_byte(reload_byte),
    .rxd_in(rxd_in),
    .rxd_out(rxd_out),
    .rxd_oe_n(rxd_oe_n),
    .txd(txd)
  );
  esp_remote_model peer_u (
    .ref_clk(ref_clk),
    .txd(txd),
    .rxd_out(rxd_out),
    .rxd_oe_n(rxd_oe_n),
    .rxd_in(rxd_in)
  );

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'h1;
    @(posedge ref_clk);
    bus.wr <= 1'h0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.rd <= 1'h1;
    @(posedge ref_clk);
    bus.rd <= 1'h0;
    #1 d = rdata;
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    reg_rd(a, v);
    check($sformatf("reg %h", a), v, e);
  endtask
  function automatic int bit_period(input logic [1:0] m, input logic dbl,
      input logic sel, input logic [7:0] th, input logic [15:0] rate);
    if (m == 2'h0) return 16;
    if (m == 2'h2) return dbl ? 16 : 32;
    if (sel) return int'(rate) + 16;
    return (256 - int'(th)) * (dbl ? 32 : 64);
  endfunction
  function automatic logic [10:0] frame(input logic [7:0] d,
      input logic nine, input logic stop, input logic nine_on);
    return nine_on ? {stop, nine, d, 1'h0} : {1'h0, stop, d, 1'h0};
  endfunction
  task automatic check_tx(input logic [10:0] bits, input int n,
      input int p);
    repeat (p / 2) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      #1 check("txd bit", {7'h00, txd}, {7'h00, bits[i]});
      repeat (p) @(posedge ref_clk);
    end
  endtask
  task automatic check_shift(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      repeat (4) @(posedge ref_clk);
      #1 check("shift clock low", {7'h00, txd}, 8'h00);
      check("shift data", {6'h00, rxd_oe_n, rxd_out}, {7'h00, d[i]});
      repeat (8) @(posedge ref_clk);
      #1 check("shift clock high", {7'h00, txd}, 8'h01);
      repeat (4) @(posedge ref_clk);
    end
  endtask
  task automatic run_tx(input logic [1:0] m, input logic dbl,
      input logic sel, input logic nine);
    logic [7:0] d;
    logic [15:0] rate;
    int p;
    d = 8'($urandom);
    rate = 16'($urandom_range(12));
    reload_byte <= 8'hff - 8'($urandom_range(1));
    reg_wr(ESP_OFF_BAUD_GEN_CONTROL, 8'h00);
    reg_wr(ESP_OFF_BAUD_RATE_LOW, rate[7:0]);
    reg_wr(ESP_OFF_BAUD_RATE_HIGH, rate[15:8]);
    reg_wr(ESP_OFF_BAUD_GEN_CONTROL, {6'h00, sel, 1'h1});
    reg_wr(ESP_OFF_POWER_CONTROL, {dbl, 7'h00});
    reg_wr(ESP_OFF_SERIAL_CONTROL, {m, 2'h0, nine, 3'h0});
    p = bit_period(m, dbl, sel, reload_byte, rate);
    reg_wr(ESP_OFF_SERIAL_DATA_BUFFER, d);
    if (m == 2'h0)
      check_shift(d);
    else
      check_tx(frame(d, nine, 1'h1, m[1]), m[1] ? 11 : 10, p);
    if (m != 2'h0)
      #1 check("idle txd", {7'h00, txd}, 8'h01);
    expect_reg(ESP_OFF_SERIAL_CONTROL, {m, 2'h0, nine, 3'h2});
    reg_wr(ESP_OFF_SERIAL_CONTROL, {m, 2'h0, nine, 3'h0});
  endtask
  task automatic run_rx(input logic [1:0] m, input logic mp,
      input logic ren, input logic nine, input logic stop);
    logic [7:0] d;
    logic [7:0] v;
    logic flag;
    d = 8'($urandom);
    flag = ren && !(m[1] && mp && !nine);
    reg_wr(ESP_OFF_SERIAL_CONTROL, {m, mp, ren, 4'h0});
    peer_u.send_frame(frame(d, nine, stop, m[1]), m[1] ? 11 : 10, 20);
    repeat (4) @(posedge ref_clk);
    reg_rd(ESP_OFF_SERIAL_CONTROL, v);
    check("rx flag", {7'h00, v[0]}, {7'h00, flag});
    if (flag) begin
      check("ninth", {7'h00, v[2]}, {7'h00, m[1] ? nine : stop});
      expect_reg(ESP_OFF_SERIAL_DATA_BUFFER, d);
    end
    expect_reg(ESP_OFF_SERIAL_STATUS, {4'h0, ren & ~stop, 3'h0});
    if (ren & ~stop) begin
      reg_wr(ESP_OFF_POWER_CONTROL, 8'h40);
      reg_rd(ESP_OFF_SERIAL_CONTROL, v);
      check("error view", {7'h00, v[7]}, 8'h01);
      reg_wr(ESP_OFF_SERIAL_CONTROL, {1'h0, m[0], mp, ren, 4'h0});
      expect_reg(ESP_OFF_SERIAL_STATUS, 8'h00);
      reg_wr(ESP_OFF_POWER_CONTROL, 8'h00);
      reg_rd(ESP_OFF_SERIAL_CONTROL, v);
      check("mode view", {7'h00, v[7]}, {7'h00, m[1]});
    end
    reg_wr(ESP_OFF_SERIAL_STATUS, 8'h00);
  endtask

  initial begin
    logic [7:0] v;
    logic [7:0] w;
    void'($urandom(40579));
    repeat (20) @(posedge ref_clk);
    rst <= 1'h0;
    foreach (REGS[i])
      expect_reg(REGS[i], 8'h00);
    $display("test reset values done");
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom);
      reg_wr(ESP_OFF_SERIAL_OWN_ADDRESS, v);
      reg_wr(ESP_OFF_SERIAL_ADDRESS_MASK, ~v);
      reg_wr(8'h90, v);
      expect_reg(ESP_OFF_SERIAL_OWN_ADDRESS, v);
      expect_reg(ESP_OFF_SERIAL_ADDRESS_MASK, ~v);
      expect_reg(8'h90, 8'h00);
      reg_wr(ESP_OFF_BAUD_GEN_CONTROL, v);
      expect_reg(ESP_OFF_BAUD_GEN_CONTROL, {6'h00, v[1:0]});
    end
    $display("test storage done");
    for (int k = 0; k < 7; k++)
      run_tx(MODES[k], k[0], SELS[k], 1'($urandom));
    $display("test transmit modes done");
    reg_wr(ESP_OFF_BAUD_GEN_CONTROL, 8'h00);
    reg_wr(ESP_OFF_BAUD_RATE_LOW, 8'h04);
    reg_wr(ESP_OFF_BAUD_RATE_HIGH, 8'h00);
    reg_wr(ESP_OFF_BAUD_GEN_CONTROL, 8'h03);
    reg_wr(ESP_OFF_POWER_CONTROL, 8'h00);
    run_rx(2'h1, 1'h0, 1'h1, 1'h0, 1'h1);
    run_rx(2'h1, 1'h0, 1'h1, 1'h0, 1'h0);
    run_rx(2'h1, 1'h0, 1'h0, 1'h0, 1'h1);
    run_rx(2'h3, 1'h1, 1'h1, 1'h0, 1'h1);
    run_rx(2'h3, 1'h1, 1'h1, 1'h1, 1'h0);
    run_rx(2'h3, 1'h0, 1'h1, 1'($urandom), 1'h1);
    $display("test receive done");
    reg_wr(ESP_OFF_BAUD_GEN_CONTROL, 8'h02);
    reg_wr(ESP_OFF_SERIAL_CONTROL, 8'h40);
    reg_wr(ESP_OFF_SERIAL_DATA_BUFFER, 8'ha5);
    repeat (200) @(posedge ref_clk);
    #1 check("frozen txd", {7'h00, txd}, 8'h00);
    expect_reg(ESP_OFF_SERIAL_CONTROL, 8'h40);
    reg_wr(ESP_OFF_BAUD_GEN_CONTROL, 8'h03);
    repeat (230) @(posedge ref_clk);
    expect_reg(ESP_OFF_SERIAL_CONTROL, 8'h42);
    $display("test halted generator done");
    v = 8'($urandom);
    peer_u.arm_shift(v, 8);
    reg_wr(ESP_OFF_SERIAL_CONTROL, 8'h10);
    repeat (140) @(posedge ref_clk);
    reg_rd(ESP_OFF_SERIAL_CONTROL, w);
    check("shift rx flag", w & 8'hfb, 8'h11);
    expect_reg(ESP_OFF_SERIAL_DATA_BUFFER, v);
    reg_wr(ESP_OFF_SERIAL_CONTROL, 8'h00);
    peer_u.arm_shift(8'h00, 0);
    $display("test shift receive done");
    report_and_stop();
  end
endmodule
`default_nettype wire
